// ===== core/bfp_defines.svh
// Offsets, field positions, reset values and timing counts of the buck protection block
`ifndef BFP_DEFINES_SVH
`define BFP_DEFINES_SVH
`define BFP_CLK_MHZ 125
`define BFP_PG_FALL_NS 50000
`define BFP_PG_FALL_CYC ((`BFP_PG_FALL_NS * `BFP_CLK_MHZ + 999) / 1000)
`define BFP_PG_RISE_NS 1000000
`define BFP_PG_RISE_CYC ((`BFP_PG_RISE_NS * `BFP_CLK_MHZ + 999) / 1000)
`define BFP_OC_LIMIT 15
`define BFP_HICCUP_SS_CYCLES 7
`define BFP_SC_RETRY_LIMIT 7
`define BFP_REG_LATCH_CFG 8'h00
`define BFP_REG_HICCUP_CFG 8'h04
`define BFP_REG_PG_SEL 8'h08
`define BFP_REG_ALERT_SEL 8'h0c
`define BFP_REG_LATCH_STATUS 8'h10
`define BFP_REG_ALERT_STATUS 8'h14
`define BFP_REG_CHAN_STATUS 8'h18
`define BFP_PG_SEL_RST 4'h1
`define BFP_ALERT_SEL_RST 6'h00
`define BFP_ALERT_OVERHEAT 0
`define BFP_ALERT_LOW_INPUT 1
`define BFP_ALERT_PG_BASE 2
`define BFP_RESP_OKAY 2'b00
`define BFP_RESP_SLVERR 2'b10
`endif

// ===== core/bfp_pkg.sv
// Types shared by the buck protection block
package bfp_pkg;
    typedef enum logic [2:0] {
        CH_OFF, CH_SOFT_START, CH_RUN, CH_HICCUP_WAIT, CH_LATCHED
    } bfp_chan_state_type;
endpackage

// ===== core/bfp_fault_protect.sv
// Four-channel buck fault protection, power-good and alert logic with AXI4-Lite registers
`include "bfp_defines.svh"

// Behaviour
// RULE1 - Feedback below half target halves frequency
// RULE2 - Below quarter target, quarter frequency
// RULE3 - Max duty skips alternate, then two of three
// RULE4 - Current limit: high-side off, low-side on
// RULE5 - Counter overflows at 15, both switches off
// RULE6 - Seven soft-starts off, then restart
// RULE7 - Hiccup masked during first soft start
// RULE8 - Hiccup disable bit keeps foldback only
// RULE9 - Seven failed restarts latch channel off
// RULE10 - Latch-off clears only on re-enable/power-cycle
// RULE11 - No short latch when hiccup disabled
// RULE12 - Overvoltage latch enable shuts channel immediately
// RULE13 - Latch status clears on write-one, fault absent
// RULE14 - Supply lockout turns channel off, restarts
// RULE15 - First channel supply gates all others
// RULE16 - Channel power good with 50 us fall filter
// RULE17 - Power good output: AND, 1 ms rise
// RULE18 - Selectable power-good channels, default channel 1
// RULE19 - Alert open-drain, active low
// RULE20 - Six alert sources, enables default cleared
// RULE21 - Six-bit sticky alert cause field
// RULE22 - Cause clears on write-one, enables low, reset
// RULE23 - Power-good alert on one-to-zero edge
// RULE24 - Fault counter clears on clean restart, enable
module bfp_fault_protect #(
    parameter int NUM_CH = 4,
    parameter int PG_FALL_CYC = `BFP_PG_FALL_CYC,
    parameter int PG_RISE_CYC = `BFP_PG_RISE_CYC
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic [NUM_CH-1:0] i_channel_enable_pins,
    input wire logic [NUM_CH-1:0] i_supply_ok,
    input wire logic [NUM_CH-1:0] i_fb_below_half,
    input wire logic [NUM_CH-1:0] i_fb_below_quarter,
    input wire logic [NUM_CH-1:0] i_duty_max,
    input wire logic [NUM_CH-1:0] i_duty_beyond_max,
    input wire logic [NUM_CH-1:0] i_over_current,
    input wire logic [NUM_CH-1:0] i_over_voltage,
    input wire logic [NUM_CH-1:0] i_pg_above_upper,
    input wire logic [NUM_CH-1:0] i_pg_below_lower,
    input wire logic [NUM_CH-1:0] i_cycle_start,
    input wire logic [NUM_CH-1:0] i_soft_start_done,
    input wire logic [NUM_CH-1:0] i_fuse_short_latch,
    input wire logic [NUM_CH-1:0] i_fuse_ovp_latch,
    input wire logic [NUM_CH-1:0] i_fuse_pg_select,
    input wire logic i_fuse_pg_select_en,
    input wire logic i_overheat,
    input wire logic i_low_input,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [NUM_CH-1:0] o_chan_run,
    output logic [NUM_CH-1:0] o_soft_start_req,
    output logic [NUM_CH-1:0] o_high_side_en,
    output logic [NUM_CH-1:0] o_low_side_en,
    output logic [NUM_CH*2-1:0] o_fold_div_shift,
    output logic [NUM_CH*2-1:0] o_skip_mode,
    output logic o_power_good_output_o,
    output logic o_power_good_output_oe,
    output logic o_alert_n_o,
    output logic o_alert_n_oe
);
    localparam int AW = 8;
    localparam int PGW = $clog2(PG_RISE_CYC + 1);

    initial begin
        if (NUM_CH != 4) begin
            $error("bfp_fault_protect serves exactly four channels");
        end
        if (PG_FALL_CYC < 1 || PG_RISE_CYC < 1) begin
            $error("bfp_fault_protect timing counts must be at least one");
        end
    end

    // Analog comparator levels pass two flops each
    localparam int SW = NUM_CH * 15 + 3;

    typedef struct packed {
        logic [SW-1:0] sync1;
        logic [SW-1:0] sync2;
        logic [NUM_CH-1:0] en_prev;
        bfp_pkg::bfp_chan_state_type [NUM_CH-1:0] st;
        logic [NUM_CH-1:0][3:0] oc_cnt;
        logic [NUM_CH-1:0][2:0] ss_cnt;
        logic [NUM_CH-1:0][2:0] retry_cnt;
        logic [NUM_CH-1:0] first_ss;
        logic [NUM_CH-1:0] limited;
        logic [NUM_CH-1:0] chan_pg;
        logic [NUM_CH-1:0][PGW-1:0] pg_fall_cnt;
        logic [PGW-1:0] pg_rise_cnt;
        logic [NUM_CH-1:0] short_latch_enable;
        logic [NUM_CH-1:0] overvolt_latch_enable;
        logic [NUM_CH-1:0] hiccup_disable;
        logic [NUM_CH-1:0] power_good_select;
        logic [5:0] alert_select;
        logic [NUM_CH*2-1:0] latch_status;
        logic [5:0] alert_cause;
        logic aw_got;
        logic w_got;
        logic [AW-1:0] aw_addr;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [NUM_CH-1:0] run;
        logic [NUM_CH-1:0] ss_req;
        logic [NUM_CH-1:0] hs_en;
        logic [NUM_CH-1:0] ls_en;
        logic [NUM_CH*2-1:0] fold;
        logic [NUM_CH*2-1:0] skip;
        logic pg_out;
        logic alert_low;
    } bfp_state_type;

    bfp_state_type state_ff;
    bfp_state_type nxt_state;

    logic [SW-1:0] raw_in;
    assign raw_in = {i_fuse_pg_select_en, i_low_input, i_overheat, i_channel_enable_pins,
        i_supply_ok, i_fb_below_half, i_fb_below_quarter, i_duty_max, i_duty_beyond_max,
        i_over_current, i_over_voltage, i_pg_above_upper, i_pg_below_lower,
        i_cycle_start, i_soft_start_done, i_fuse_short_latch, i_fuse_ovp_latch,
        i_fuse_pg_select};

    always_comb begin
        logic [NUM_CH-1:0] en, sup, fbh, fbq, dmax, dbey, oc, ov, pgu, pgl, cyc, ssd;
        logic [NUM_CH-1:0] fsc, fov, fpg, sup_eff, pg_sel, sc_on, ov_on;
        logic [NUM_CH*2-1:0] wr1_lch;
        logic fpg_en, lowin, hot, wr, rd, all_pg;
        logic [5:0] cause_set, wr1_alert;
        nxt_state = state_ff;
        {fpg_en, lowin, hot, en, sup, fbh, fbq, dmax, dbey, oc, ov, pgu, pgl, cyc, ssd,
            fsc, fov, fpg} = state_ff.sync2;
        nxt_state.sync1 = raw_in;
        nxt_state.sync2 = state_ff.sync1;
        nxt_state.en_prev = en;
        // First-channel lockout holds all off [RULE15]
        sup_eff = sup & {NUM_CH{sup[0]}};
        sc_on = (state_ff.short_latch_enable | fsc) & ~state_ff.hiccup_disable; // [RULE11]
        ov_on = state_ff.overvolt_latch_enable | fov;

        // Write: aw and w in either order
        wr = state_ff.aw_got && state_ff.w_got && !state_ff.bvalid;
        wr1_lch = '0;
        wr1_alert = '0;
        if (s_axi_awvalid && !state_ff.aw_got) begin
            nxt_state.aw_got = 1'b1;
            nxt_state.aw_addr = s_axi_awaddr[AW-1:0];
        end
        if (s_axi_wvalid && !state_ff.w_got) begin
            nxt_state.w_got = 1'b1;
            nxt_state.w_data = s_axi_wdata;
            nxt_state.w_strb = s_axi_wstrb;
        end
        if (wr) begin
            nxt_state.aw_got = 1'b0;
            nxt_state.w_got = 1'b0;
            nxt_state.bvalid = 1'b1;
            nxt_state.bresp = `BFP_RESP_OKAY;
            if (state_ff.w_strb[0]) begin
                case (state_ff.aw_addr)
                    `BFP_REG_LATCH_CFG: begin
                        nxt_state.short_latch_enable = state_ff.w_data[3:0];
                        nxt_state.overvolt_latch_enable = state_ff.w_data[7:4];
                    end
                    `BFP_REG_HICCUP_CFG: nxt_state.hiccup_disable = state_ff.w_data[3:0];
                    `BFP_REG_PG_SEL: nxt_state.power_good_select = state_ff.w_data[3:0];
                    `BFP_REG_ALERT_SEL: nxt_state.alert_select = state_ff.w_data[5:0];
                    `BFP_REG_LATCH_STATUS: wr1_lch = state_ff.w_data[7:0];
                    `BFP_REG_ALERT_STATUS: wr1_alert = state_ff.w_data[5:0];
                    `BFP_REG_CHAN_STATUS: ;
                    default: nxt_state.bresp = `BFP_RESP_SLVERR;
                endcase
            end else if (state_ff.aw_addr > `BFP_REG_CHAN_STATUS ||
                    state_ff.aw_addr[1:0] != 2'b00) begin
                nxt_state.bresp = `BFP_RESP_SLVERR;
            end
        end
        if (state_ff.bvalid && s_axi_bready) begin
            nxt_state.bvalid = 1'b0;
        end
        rd = s_axi_arvalid && !state_ff.rvalid;
        if (rd) begin
            nxt_state.rvalid = 1'b1;
            nxt_state.rresp = `BFP_RESP_OKAY;
            case (s_axi_araddr[AW-1:0])
                `BFP_REG_LATCH_CFG: nxt_state.rdata = {24'h000000,
                    state_ff.overvolt_latch_enable, state_ff.short_latch_enable};
                `BFP_REG_HICCUP_CFG: nxt_state.rdata = {28'h0000000, state_ff.hiccup_disable};
                `BFP_REG_PG_SEL: nxt_state.rdata = {28'h0000000, state_ff.power_good_select};
                `BFP_REG_ALERT_SEL: nxt_state.rdata = {26'h0000000, state_ff.alert_select};
                `BFP_REG_LATCH_STATUS: nxt_state.rdata = {24'h000000, state_ff.latch_status};
                `BFP_REG_ALERT_STATUS: nxt_state.rdata = {26'h0000000, state_ff.alert_cause};
                `BFP_REG_CHAN_STATUS: nxt_state.rdata = {24'h000000, state_ff.oc_cnt[0],
                    state_ff.chan_pg};
                default: begin
                    nxt_state.rdata = 32'h00000000;
                    nxt_state.rresp = `BFP_RESP_SLVERR;
                end
            endcase
        end
        if (state_ff.rvalid && s_axi_rready) begin
            nxt_state.rvalid = 1'b0;
        end

        for (int c = 0; c < NUM_CH; c++) begin
            logic oc_evt;
            oc_evt = oc[c] && !state_ff.limited[c];
            // Foldback in every state [RULE1] [RULE2] [RULE8]
            nxt_state.fold[2*c +: 2] = fbq[c] ? 2'd2 : (fbh[c] ? 2'd1 : 2'd0);
            // Pulse skipping: 1 = skip alternate, 2 = skip two of three [RULE3]
            nxt_state.skip[2*c +: 2] = dbey[c] ? 2'd2 : (dmax[c] ? 2'd1 : 2'd0);
            // Current limit holds for the rest of the switching cycle [RULE4]
            if (cyc[c]) begin
                nxt_state.limited[c] = 1'b0;
            end else if (oc[c]) begin
                nxt_state.limited[c] = 1'b1;
            end

            case (state_ff.st[c])
                bfp_pkg::CH_OFF: begin
                    if (en[c] && sup_eff[c]) begin // [RULE14]
                        nxt_state.st[c] = bfp_pkg::CH_SOFT_START;
                        nxt_state.first_ss[c] = 1'b1;
                        nxt_state.oc_cnt[c] = 4'h0; // [RULE24]
                        nxt_state.retry_cnt[c] = 3'h0;
                    end
                end
                bfp_pkg::CH_SOFT_START: begin
                    // Hiccup masked in first soft start [RULE7]
                    if (oc_evt && !state_ff.first_ss[c] && !state_ff.hiccup_disable[c]) begin
                        nxt_state.oc_cnt[c] = state_ff.oc_cnt[c] + 4'h1;
                    end
                    if (ssd[c]) begin
                        nxt_state.st[c] = bfp_pkg::CH_RUN;
                        nxt_state.first_ss[c] = 1'b0;
                    end
                end
                bfp_pkg::CH_RUN: begin
                    if (oc_evt && !state_ff.hiccup_disable[c]) begin // [RULE5] [RULE8]
                        nxt_state.oc_cnt[c] = state_ff.oc_cnt[c] + 4'h1;
                    end
                end
                bfp_pkg::CH_HICCUP_WAIT: begin
                    // Off for seven soft-start durations, then restart [RULE6]
                    if (ssd[c]) begin
                        nxt_state.ss_cnt[c] = state_ff.ss_cnt[c] + 3'h1;
                        if (state_ff.ss_cnt[c] == 3'(`BFP_HICCUP_SS_CYCLES - 1)) begin
                            nxt_state.ss_cnt[c] = 3'h0;
                            nxt_state.st[c] = bfp_pkg::CH_SOFT_START;
                        end
                    end
                end
                bfp_pkg::CH_LATCHED: ;
                default: nxt_state.st[c] = bfp_pkg::CH_OFF;
            endcase

            // Overflow at 15: both switches off [RULE5]
            if ((state_ff.st[c] == bfp_pkg::CH_RUN || state_ff.st[c] == bfp_pkg::CH_SOFT_START)
                    && state_ff.oc_cnt[c] == 4'(`BFP_OC_LIMIT) && oc_evt
                    && !state_ff.hiccup_disable[c] && !state_ff.first_ss[c]) begin
                nxt_state.oc_cnt[c] = 4'h0;
                nxt_state.ss_cnt[c] = 3'h0;
                nxt_state.st[c] = bfp_pkg::CH_HICCUP_WAIT;
                nxt_state.retry_cnt[c] = state_ff.retry_cnt[c] + 3'h1;
                if (sc_on[c] && state_ff.retry_cnt[c] == 3'(`BFP_SC_RETRY_LIMIT - 1)) begin
                    nxt_state.st[c] = bfp_pkg::CH_LATCHED; // [RULE9]
                    nxt_state.latch_status[c] = 1'b1;
                end
            end else if (state_ff.st[c] == bfp_pkg::CH_RUN && cyc[c] && !oc[c]
                    && state_ff.oc_cnt[c] == 4'h0) begin
                nxt_state.retry_cnt[c] = 3'h0; // A clean cycle ends the retry run [RULE24]
            end
            if (state_ff.st[c] == bfp_pkg::CH_SOFT_START && ssd[c] && !state_ff.limited[c]) begin
                nxt_state.oc_cnt[c] = 4'h0; // [RULE24]
            end
            // Overvoltage latches at once [RULE12]
            if (ov_on[c] && ov[c] && state_ff.st[c] != bfp_pkg::CH_OFF
                    && state_ff.st[c] != bfp_pkg::CH_LATCHED) begin
                nxt_state.st[c] = bfp_pkg::CH_LATCHED;
                nxt_state.latch_status[NUM_CH + c] = 1'b1;
            end
            // Enable low or lockout: off, the only exit from latch-off [RULE10] [RULE14]
            if (!en[c] || !sup_eff[c]) begin
                nxt_state.st[c] = bfp_pkg::CH_OFF;
            end
            // W1C while fault absent; a set needs the fault, so it wins [RULE13]
            if (wr1_lch[c] && !(sc_on[c] && oc[c])
                    && state_ff.st[c] != bfp_pkg::CH_LATCHED) begin
                nxt_state.latch_status[c] = 1'b0;
            end
            if (wr1_lch[NUM_CH + c] && !ov[c]) begin
                nxt_state.latch_status[NUM_CH + c] = 1'b0;
            end

            // Set above upper, clear after long low [RULE16]
            if (pgu[c]) begin
                nxt_state.chan_pg[c] = 1'b1;
                nxt_state.pg_fall_cnt[c] = '0;
            end else if (pgl[c] && state_ff.chan_pg[c]) begin
                if (state_ff.pg_fall_cnt[c] == PGW'(PG_FALL_CYC)) begin
                    nxt_state.chan_pg[c] = 1'b0;
                    nxt_state.pg_fall_cnt[c] = '0;
                end else begin
                    nxt_state.pg_fall_cnt[c] = state_ff.pg_fall_cnt[c] + PGW'(1);
                end
            end else begin
                nxt_state.pg_fall_cnt[c] = '0;
            end

            nxt_state.run[c] = nxt_state.st[c] == bfp_pkg::CH_RUN ||
                nxt_state.st[c] == bfp_pkg::CH_SOFT_START;
            nxt_state.ss_req[c] = nxt_state.st[c] == bfp_pkg::CH_SOFT_START;
            // Limit: high-side off, low-side on; hiccup or latch: both off [RULE4] [RULE5]
            nxt_state.hs_en[c] = nxt_state.run[c] && !nxt_state.limited[c];
            nxt_state.ls_en[c] = nxt_state.run[c];
        end

        // Power-good output from selected channels, 1 ms qualified rise [RULE17] [RULE18]
        pg_sel = fpg_en ? fpg : state_ff.power_good_select;
        all_pg = &(state_ff.chan_pg | ~pg_sel);
        if (!all_pg) begin
            nxt_state.pg_rise_cnt = '0;
            nxt_state.pg_out = 1'b0;
        end else if (state_ff.pg_rise_cnt == PGW'(PG_RISE_CYC)) begin
            nxt_state.pg_out = 1'b1;
        end else begin
            nxt_state.pg_rise_cnt = state_ff.pg_rise_cnt + PGW'(1);
        end

        // Alert causes: overheat, low input, power-good falls per channel [RULE21] [RULE23]
        cause_set = {state_ff.chan_pg & ~nxt_state.chan_pg, lowin, hot};
        // Clear on write-one or all enables low; set wins [RULE22]
        nxt_state.alert_cause = (state_ff.alert_cause & ~wr1_alert & {6{|en}}) | cause_set;
        // Alert pin low while an enabled cause stands [RULE19] [RULE20]
        nxt_state.alert_low = |(nxt_state.alert_cause & nxt_state.alert_select);
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state_ff <= '0;
            state_ff.power_good_select <= `BFP_PG_SEL_RST; // [RULE18]
            state_ff.alert_select <= `BFP_ALERT_SEL_RST; // [RULE20]
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign s_axi_awready = !state_ff.aw_got;
    assign s_axi_wready = !state_ff.w_got;
    assign s_axi_bvalid = state_ff.bvalid;
    assign s_axi_bresp = state_ff.bresp;
    assign s_axi_arready = !state_ff.rvalid;
    assign s_axi_rvalid = state_ff.rvalid;
    assign s_axi_rdata = state_ff.rdata;
    assign s_axi_rresp = state_ff.rresp;
    assign o_chan_run = state_ff.run;
    assign o_soft_start_req = state_ff.ss_req;
    assign o_high_side_en = state_ff.hs_en;
    assign o_low_side_en = state_ff.ls_en;
    assign o_fold_div_shift = state_ff.fold;
    assign o_skip_mode = state_ff.skip;
    // Open-drain: enable low drive only, released otherwise [RULE17] [RULE19]
    assign o_power_good_output_o = 1'b0;
    assign o_power_good_output_oe = !state_ff.pg_out;
    assign o_alert_n_o = 1'b0;
    assign o_alert_n_oe = state_ff.alert_low;
endmodule

// ===== verif/bfp_host_model.sv
// Host-side open-drain lines
module bfp_host_model (
    input wire logic i_pg_o,
    input wire logic i_pg_oe,
    input wire logic i_alert_o,
    input wire logic i_alert_oe,
    output logic o_pg_line,
    output logic o_alert_n_line
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pull-ups while released
    assign o_pg_line = i_pg_oe ? i_pg_o : 1'b1;
    assign o_alert_n_line = i_alert_oe ? i_alert_o : 1'b1;
endmodule

// ===== verif/bfp_fault_protect_asserts.sv
// Port checks of the buck protection block
module bfp_fault_protect_asserts #(
    parameter int PG_FALL_CYC = 5,
    parameter int PG_RISE_CYC = 20
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic [3:0] i_fb_below_half,
    input wire logic [3:0] i_fb_below_quarter,
    input wire logic [3:0] i_duty_beyond_max,
    input wire logic [3:0] i_over_current,
    input wire logic [3:0] i_over_voltage,
    input wire logic [3:0] i_fuse_ovp_latch,
    input wire logic [3:0] i_supply_ok,
    input wire logic [3:0] i_pg_above_upper,
    input wire logic [3:0] i_pg_below_lower,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] s_axi_rresp,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [3:0] o_chan_run,
    input wire logic [3:0] o_high_side_en,
    input wire logic [7:0] o_fold_div_shift,
    input wire logic [7:0] o_skip_mode,
    input wire logic o_power_good_output_o,
    input wire logic o_power_good_output_oe,
    input wire logic o_alert_n_o,
    input wire logic o_alert_n_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    // Long filters are counted, not unrolled
    logic [31:0] lowc;
    logic [31:0] upc;
    always_ff @(posedge i_clk) begin
        lowc <= (i_srst || !i_pg_below_lower[0]) ? '0 : lowc + 1;
        upc <= (i_srst || !i_pg_above_upper[0]) ? '0 : upc + 1;
    end
    fold_half_a: assert property (
        (i_fb_below_half[0] && !i_fb_below_quarter[0] && o_chan_run[0])[*4]
        |-> o_fold_div_shift[1:0] == 2'h1) else $error("fold half missing");
    fold_quarter_a: assert property (
        (i_fb_below_quarter[0] && o_chan_run[0])[*4]
        |-> o_fold_div_shift[1:0] == 2'h2) else $error("fold quarter missing");
    skip_two_a: assert property (
        (i_duty_beyond_max[0] && o_chan_run[0])[*4]
        |-> o_skip_mode[1:0] == 2'h2) else $error("skip mode wrong");
    limit_off_a: assert property (
        (i_over_current[0] && o_chan_run[0])[*4] |-> !o_high_side_en[0])
        else $error("high side on at limit");
    ovp_stop_a: assert property (
        (i_over_voltage[1] && i_fuse_ovp_latch[1])[*4] |-> !o_chan_run[1])
        else $error("overvoltage ignored");
    first_supply_a: assert property (
        (!i_supply_ok[0])[*4] |-> o_chan_run == 4'h0) else $error("runs without supply");
    pg_fall_a: assert property (
        lowc > PG_FALL_CYC + 4 |-> o_power_good_output_oe) else $error("pg not dropped");
    pg_rise_a: assert property (
        $fell(o_power_good_output_oe) |-> upc >= PG_RISE_CYC) else $error("pg released early");
    drain_low_a: assert property (
        !o_alert_n_o && !o_power_good_output_o) else $error("open drain drives high");
    bresp_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    rdata_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    cover property ($fell(o_power_good_output_oe));
    cover property ($rose(o_alert_n_oe));
    cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule

// ===== verif/bfp_fault_protect_tb.sv
// Bench for the buck protection block
module bfp_fault_protect_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int FALL = 5;
    localparam int RISE = 20;
    logic i_clk = 0, i_srst = 1, i_fuse_pg_select_en = 0, i_overheat = 0, i_low_input = 0;
    logic [3:0] i_channel_enable_pins = '0, i_supply_ok = '0, i_fb_below_half = '0;
    logic [3:0] i_fb_below_quarter = '0, i_duty_max = '0, i_duty_beyond_max = '0;
    logic [3:0] i_over_current = '0, i_over_voltage = '0, i_pg_above_upper = '0;
    logic [3:0] i_pg_below_lower = '0, i_cycle_start = '0, i_soft_start_done = '0;
    logic [3:0] i_fuse_short_latch = '0, i_fuse_ovp_latch = '0, i_fuse_pg_select = '0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic o_power_good_output_o, o_power_good_output_oe, o_alert_n_o, o_alert_n_oe;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [3:0] o_chan_run, o_soft_start_req, o_high_side_en, o_low_side_en;
    logic [7:0] o_fold_div_shift, o_skip_mode;
    logic pg_line, alert_line;
    int fails = 0, n_tests = 0;
    always #4 i_clk = ~i_clk;
    bfp_fault_protect #(.PG_FALL_CYC(FALL), .PG_RISE_CYC(RISE)) i_dut (.*);
    bfp_host_model i_host (.i_pg_o(o_power_good_output_o), .i_pg_oe(o_power_good_output_oe),
        .i_alert_o(o_alert_n_o), .i_alert_oe(o_alert_n_oe), .o_pg_line(pg_line),
        .o_alert_n_line(alert_line));
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic tmo(input int n);
        if (n >= 50) begin
            fails++;
            $display("[FAIL] %0t bus wait timed out", $time);
            stop_test();
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
        s_axi_awaddr <= {24'h0, a}; s_axi_wdata <= d;
        do begin
            @(posedge i_clk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid && n < 50);
        s_axi_bready <= 0;
        tmo(n);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
        int n;
        n = 0;
        s_axi_arvalid <= 1; s_axi_rready <= 1; s_axi_araddr <= {24'h0, a};
        do begin
            @(posedge i_clk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid && n < 50);
        s_axi_rready <= 0;
        chk(s_axi_rdata, e);
        chk(s_axi_rresp, r);
        tmo(n);
    endtask
    // One-cycle soft-start end pulse
    task automatic ss(input logic [3:0] m);
        i_soft_start_done <= m; w(1); i_soft_start_done <= 4'h0; w(5);
    endtask
    initial begin
        w(6); i_srst <= 0; w(3);
        rd(8'h08, 32'h1);
        rd(8'h0c, 32'h0);
        rd(8'h40, 32'h0, 2'h2);
        i_channel_enable_pins <= 4'hf; i_supply_ok <= 4'hf; w(5); ss(4'hf);
        chk(o_chan_run, 32'hf);
        i_fb_below_half <= 4'hf; w(6); chk(o_fold_div_shift, 32'h55);
        i_fb_below_quarter <= 4'hf; w(6); chk(o_fold_div_shift, 32'haa);
        i_fb_below_half <= 4'h0; i_fb_below_quarter <= 4'h0; i_duty_max <= 4'hf; w(6);
        chk(o_skip_mode, 32'h55);
        i_duty_beyond_max <= 4'hf; w(6); chk(o_skip_mode, 32'haa);
        i_duty_max <= 4'h0; i_duty_beyond_max <= 4'h0; i_pg_above_upper <= 4'hf;
        w(RISE + 10); chk(pg_line, 32'h1);
        rd(8'h18, 32'hf);
        wr(8'h0c, 32'h4); i_pg_above_upper <= 4'he; i_pg_below_lower <= 4'h1;
        w(FALL - 2); chk(pg_line, 32'h1);
        w(10); chk(pg_line, 32'h0);
        chk(alert_line, 32'h0);
        rd(8'h14, 32'h4);
        wr(8'h14, 32'h0); rd(8'h14, 32'h4);
        wr(8'h14, 32'h4); rd(8'h14, 32'h0); chk(alert_line, 32'h1);
        repeat (16) begin
            i_cycle_start <= 4'h1; w(1); i_cycle_start <= 4'h0; i_over_current <= 4'h1; w(4);
            chk(o_high_side_en[0], 32'h0);
            i_over_current <= 4'h0; w(1);
        end
        chk({o_high_side_en[0], o_low_side_en[0]}, 32'h0);
        repeat (6) ss(4'h1);
        chk(o_soft_start_req[0], 32'h0);
        ss(4'h1); chk(o_soft_start_req[0], 32'h1);
        ss(4'h1); rd(8'h18, 32'he);
        i_fuse_ovp_latch <= 4'h2; i_over_voltage <= 4'h2; w(6);
        chk(o_chan_run[1], 32'h0);
        rd(8'h10, 32'h20);
        i_over_voltage <= 4'h0; w(4); wr(8'h10, 32'h20); rd(8'h10, 32'h0);
        ss(4'h2); chk(o_chan_run[1], 32'h0);
        i_channel_enable_pins <= 4'hd; w(5); i_channel_enable_pins <= 4'hf; w(5); ss(4'h2);
        chk(o_chan_run[1], 32'h1);
        i_supply_ok <= 4'hb; w(6); chk(o_chan_run, 32'hb);
        i_supply_ok <= 4'he; w(6); chk(o_chan_run, 32'h0);
        i_supply_ok <= 4'hf; w(6); chk(o_soft_start_req, 32'hf);
        wr(8'h0c, 32'h1); i_overheat <= 1; w(5); i_overheat <= 0; w(5);
        chk(alert_line, 32'h0);
        i_channel_enable_pins <= 4'h0; w(5); rd(8'h14, 32'h0);
        chk(alert_line, 32'h1);
        stop_test();
    end
    initial begin
        w(100000);
        fails++;
        $display("[FAIL] %0t run did not finish", $time);
        stop_test();
    end
endmodule
bind bfp_fault_protect bfp_fault_protect_asserts #(.PG_FALL_CYC(PG_FALL_CYC),
    .PG_RISE_CYC(PG_RISE_CYC)) i_chk (.*);
